// ### hw/meia_top.sv
// Purpose: latch monitoring events into a status register and raise the host interrupt
// Assumes: Avalon-MM slave with waitrequest, byte addresses, one clock
// Notes: a status read clears only the bits it returned
//
// Notes on behaviour
// RULE1 - The live-level register at index 0x51 shows the present debounced level of every event.
// RULE2 - Every event sets its status bit at index 0x4F unless it is masked.
// RULE3 - A set bit in the mask register at index 0x50 keeps its event out of the status.
// RULE4 - Mic current, mic short, left jack and right jack events fire on both edges.
// RULE5 - All other events fire only on the rising edge of their condition.
// RULE6 - Status bits stay latched until a read of the status register clears them; the code also clears bits that a status write sets to one.
// RULE7 - The interrupt request pin is low while any status bit is set.
// RULE8 - The pin returns high once the status register has been read.
// RULE9 - Status bits 15 to 12 hold mic current, mic short, left and right jack, bit 11 codec done.
// RULE10 - Status bit 10 holds the reset delay timer fault or timeout.
// RULE11 - Bit 9 holds the high temperature event and bit 8 the warning temperature event.
// RULE12 - Bit 7 holds the battery comparator event and bit 6 the supply lockout event.
// RULE13 - Bits 5 and 4 hold buck 2 and buck 1, bits 3 to 0 linear regulators 4 to 1.
// RULE14 - Mask bits share the status positions, one means masked, and both reset to zero.
// RULE15 - Live-level bits use the same positions as the status bits.
// RULE16 - Mask bits 3 to 0 mask linear regulators 4 to 1 and reset to zero.
// RULE17 - An event in the cycle of a clearing read stays latched.
`include "meia_defs.svh"

module meia_top
   import meia_pkg::*;
#(
   parameter int ADDR_W = `MEIA_ADDR_W
) (
   input wire logic core_clk_i,
   input wire logic arst_n_i,
   input wire logic [ADDR_W-1:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   input wire logic mic_current_event_i,
   input wire logic mic_short_event_i,
   input wire logic left_jack_event_i,
   input wire logic right_jack_event_i,
   input wire logic codec_sequence_done_event_i,
   input wire logic reset_delay_fault_event_i,
   input wire logic temp_high_event_i,
   input wire logic temp_warn_event_i,
   input wire logic battery_comparator_event_i,
   input wire logic supply_lockout_event_i,
   input wire logic buck2_undervoltage_event_i,
   input wire logic buck1_undervoltage_event_i,
   input wire logic linreg4_undervoltage_event_i,
   input wire logic linreg3_undervoltage_event_i,
   input wire logic linreg2_undervoltage_event_i,
   input wire logic linreg1_undervoltage_event_i,
   output logic host_interrupt_request_low_o,
   output logic irq_o
);

   meia_evvec_type cond;
   meia_evvec_type status;
   meia_evvec_type mask;
   meia_evvec_type rd_snap;
   meia_evvec_type ev_set;
   meia_evvec_type w1c_bits;
   meia_evvec_type rc_bits;
   meia_evvec_type next_status;
   meia_evvec_type next_mask;
   meia_bus_state_type bus_state;
   meia_bus_state_type next_bus_state;
   logic [31:0] next_readdata;
   logic [7:0] word_idx;
   logic aligned;
   logic req;
   logic take;
   logic done;
   logic hit_status;
   logic hit_mask;
   logic hit_live;
   logic rd_status_done;
   logic wr_status_done;
   logic wr_mask_done;
   logic [15:0] lane_mask;

   // RULE9 upper event positions
   assign cond[`MEIA_BIT_MIC_CURRENT] = mic_current_event_i;
   assign cond[`MEIA_BIT_MIC_SHORT] = mic_short_event_i;
   assign cond[`MEIA_BIT_LEFT_JACK] = left_jack_event_i;
   assign cond[`MEIA_BIT_RIGHT_JACK] = right_jack_event_i;
   assign cond[`MEIA_BIT_CODEC_DONE] = codec_sequence_done_event_i;
   // RULE10 reset delay position
   assign cond[`MEIA_BIT_RESET_DELAY] = reset_delay_fault_event_i;
   // RULE11 temperature positions
   assign cond[`MEIA_BIT_TEMP_HIGH] = temp_high_event_i;
   assign cond[`MEIA_BIT_TEMP_WARN] = temp_warn_event_i;
   // RULE12 battery and lockout
   assign cond[`MEIA_BIT_BATTERY] = battery_comparator_event_i;
   assign cond[`MEIA_BIT_LOCKOUT] = supply_lockout_event_i;
   // RULE13 regulator positions
   assign cond[`MEIA_BIT_BUCK2] = buck2_undervoltage_event_i;
   assign cond[`MEIA_BIT_BUCK1] = buck1_undervoltage_event_i;
   assign cond[`MEIA_BIT_LINREG4] = linreg4_undervoltage_event_i;
   assign cond[`MEIA_BIT_LINREG3] = linreg3_undervoltage_event_i;
   assign cond[`MEIA_BIT_LINREG2] = linreg2_undervoltage_event_i;
   assign cond[`MEIA_BIT_LINREG1] = linreg1_undervoltage_event_i;

   meia_edge_if #(.WIDTH(16)) ev_bus ();

   // conditions come from other domains, so u_edge synchronises them here in two stages
   meia_event_edge #(
      .WIDTH(16),
      .BOTH_EDGES(`MEIA_BOTH_EDGES)
   ) u_edge (
      .core_clk_i(core_clk_i),
      .arst_n_i(arst_n_i),
      .cond_i(cond),
      .ev(ev_bus.src)
   );

   // bus decode
   assign word_idx = avs_address[9:2];
   assign aligned = (avs_address[1:0] == 2'h0);
   assign req = avs_read | avs_write;
   assign hit_status = aligned && (word_idx == `MEIA_IDX_STATUS);
   assign hit_mask = aligned && (word_idx == `MEIA_IDX_MASK);
   assign hit_live = aligned && (word_idx == `MEIA_IDX_LIVE);
   // take: request seen, answer prepared; done: master sees waitrequest low
   assign take = req && (bus_state == MEIA_IDLE);
   assign done = req && (bus_state == MEIA_ANSWER);
   assign rd_status_done = done && avs_read && hit_status;
   assign wr_status_done = done && avs_write && hit_status;
   assign wr_mask_done = done && avs_write && hit_mask;
   assign lane_mask = {{8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};

   always_comb begin
      next_bus_state = bus_state;
      case (bus_state)
         MEIA_IDLE: begin
            if (req) begin
               next_bus_state = MEIA_ANSWER;
            end
         end
         MEIA_ANSWER: begin
            next_bus_state = MEIA_IDLE;
         end
         default: begin
            next_bus_state = MEIA_IDLE;
         end
      endcase
   end

   // RULE1 live level readback
   // RULE15 same positions as status
   assign next_readdata = !(take && avs_read) ? avs_readdata :
      hit_status ? {16'h0000, status} :
      hit_mask ? {16'h0000, mask} :
      hit_live ? {16'h0000, ev_bus.level} : 32'h0000_0000;

   // RULE2 unmasked events latch
   // RULE3 mask blocks latching
   assign ev_set = ev_bus.pulse & ~mask;
   // RULE6 read clears returned bits
   assign rc_bits = rd_status_done ? rd_snap : 16'h0000;
   assign w1c_bits = wr_status_done ? (avs_writedata[15:0] & lane_mask) : 16'h0000;
   // RULE17 set wins over clear
   assign next_status = (status & ~(rc_bits | w1c_bits)) | ev_set;
   // RULE14 mask positions match status
   // RULE16 low mask bits cover linear regulators
   assign next_mask = wr_mask_done ?
      ((mask & ~lane_mask) | (avs_writedata[15:0] & lane_mask)) : mask;

   always_ff @(posedge core_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         bus_state <= MEIA_IDLE;
         avs_readdata <= 32'h0000_0000;
         rd_snap <= `MEIA_STATUS_RST;
      end else begin
         bus_state <= next_bus_state;
         avs_readdata <= next_readdata;
         rd_snap <= take ? status : rd_snap;
      end
   end

   // waitrequest stays high except in the answer cycle
   always_ff @(posedge core_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         avs_waitrequest <= 1'b1;
      end else begin
         avs_waitrequest <= !(next_bus_state == MEIA_ANSWER);
      end
   end

   // RULE14 reset to zero
   always_ff @(posedge core_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         status <= `MEIA_STATUS_RST;
         mask <= `MEIA_MASK_RST;
      end else begin
         status <= next_status;
         mask <= next_mask;
      end
   end

   // RULE7 pin low while latched
   // RULE8 pin high after read
   always_ff @(posedge core_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         host_interrupt_request_low_o <= 1'b1;
         irq_o <= 1'b0;
      end else begin
         host_interrupt_request_low_o <= ~(|status);
         irq_o <= |status;
      end
   end

   // checks

   chk_live_read_value: assert property ( // RULE1
      @(posedge core_clk_i) disable iff (!arst_n_i)
      (take && avs_read && hit_live) |=> (avs_readdata == {16'h0000, $past(ev_bus.level)})
   ) else $error("live-level read returned wrong data");

   chk_unmasked_sets: assert property ( // RULE2
      @(posedge core_clk_i) disable iff (!arst_n_i)
      (|ev_set) |=> ((status & $past(ev_set)) == $past(ev_set))
   ) else $error("unmasked event did not latch");

   chk_masked_blocked: assert property ( // RULE3
      @(posedge core_clk_i) disable iff (!arst_n_i)
      ((status & ~$past(status) & $past(mask)) == 16'h0000)
   ) else $error("masked event reached status");

   chk_jack_falls: assert property ( // RULE4
      @(posedge core_clk_i) disable iff (!arst_n_i)
      ($fell(ev_bus.level[`MEIA_BIT_LEFT_JACK]) && !mask[`MEIA_BIT_LEFT_JACK])
         |=> status[`MEIA_BIT_LEFT_JACK]
   ) else $error("falling jack edge did not latch");

   chk_temp_rise_only: assert property ( // RULE5
      @(posedge core_clk_i) disable iff (!arst_n_i)
      ($fell(ev_bus.level[`MEIA_BIT_TEMP_HIGH]) && !status[`MEIA_BIT_TEMP_HIGH])
         |=> !status[`MEIA_BIT_TEMP_HIGH]
   ) else $error("falling temperature edge latched");

   chk_read_clears: assert property ( // RULE6
      @(posedge core_clk_i) disable iff (!arst_n_i)
      (rd_status_done && (ev_set == 16'h0000)) |=> ((status & $past(rd_snap)) == 16'h0000)
   ) else $error("status read did not clear bits");

   chk_pin_low: assert property ( // RULE7
      @(posedge core_clk_i) disable iff (!arst_n_i)
      (|status) |=> !host_interrupt_request_low_o
   ) else $error("interrupt pin not low with status set");

   chk_pin_release: assert property ( // RULE8
      @(posedge core_clk_i) disable iff (!arst_n_i)
      (rd_status_done && (ev_set == 16'h0000) && (status == rd_snap))
         |-> ##2 host_interrupt_request_low_o
   ) else $error("interrupt pin not released after read");

   chk_edge_kept: assert property ( // RULE17
      @(posedge core_clk_i) disable iff (!arst_n_i)
      (rd_status_done && (ev_set != 16'h0000)) |=> ((status & $past(ev_set)) == $past(ev_set))
   ) else $error("event lost in clearing read");

   chk_wait_answer: assert property ( // RULE6
      @(posedge core_clk_i) disable iff (!arst_n_i)
      (req && avs_waitrequest) |=> !avs_waitrequest
   ) else $error("waitrequest not lowered one cycle after request");

   chk_wait_single: assert property ( // RULE6
      @(posedge core_clk_i) disable iff (!arst_n_i)
      !avs_waitrequest |=> avs_waitrequest
   ) else $error("waitrequest low for more than one cycle");

   chk_snap_returned: assert property ( // RULE2
      @(posedge core_clk_i) disable iff (!arst_n_i)
      (take && avs_read && hit_status) |=> (avs_readdata == {16'h0000, $past(status)})
   ) else $error("status read returned wrong data");

   chk_mask_returned: assert property ( // RULE14
      @(posedge core_clk_i) disable iff (!arst_n_i)
      (take && avs_read && hit_mask) |=> (avs_readdata == {16'h0000, $past(mask)})
   ) else $error("mask read returned wrong data");

   chk_unmapped_zero: assert property ( // RULE14
      @(posedge core_clk_i) disable iff (!arst_n_i)
      (take && avs_read && !(hit_status || hit_mask || hit_live))
         |=> (avs_readdata == 32'h0000_0000)
   ) else $error("unmapped read returned data");

   // the first two edges after reset see synchroniser contents from reset
   chk_live_follows: assert property ( // RULE15
      @(posedge core_clk_i) disable iff (!arst_n_i)
      ($past(arst_n_i, 2) && $past(arst_n_i)) |-> (ev_bus.level == $past(cond, 2))
   ) else $error("live level does not follow its input");

   chk_mask_write: assert property ( // RULE14
      @(posedge core_clk_i) disable iff (!arst_n_i)
      (wr_mask_done && (avs_byteenable[1:0] == 2'h3)) |=> (mask == $past(avs_writedata[15:0]))
   ) else $error("full mask write did not land");

   chk_mask_hold: assert property ( // RULE3
      @(posedge core_clk_i) disable iff (!arst_n_i)
      !wr_mask_done |=> (mask == $past(mask))
   ) else $error("mask changed without a write");

   chk_status_sticky: assert property ( // RULE6
      @(posedge core_clk_i) disable iff (!arst_n_i)
      !(rd_status_done || wr_status_done) |=> ((~status & $past(status)) == 16'h0000)
   ) else $error("status bit dropped without read or write");

   chk_w1c_clears: assert property ( // RULE6
      @(posedge core_clk_i) disable iff (!arst_n_i)
      (wr_status_done && (ev_set == 16'h0000)) |=> ((status & $past(w1c_bits)) == 16'h0000)
   ) else $error("status write did not clear its bits");

   chk_mic_rises: assert property ( // RULE4
      @(posedge core_clk_i) disable iff (!arst_n_i)
      ($rose(ev_bus.level[`MEIA_BIT_MIC_CURRENT]) && !mask[`MEIA_BIT_MIC_CURRENT])
         |=> status[`MEIA_BIT_MIC_CURRENT]
   ) else $error("rising mic current edge did not latch");

   chk_short_falls: assert property ( // RULE4
      @(posedge core_clk_i) disable iff (!arst_n_i)
      ($fell(ev_bus.level[`MEIA_BIT_MIC_SHORT]) && !mask[`MEIA_BIT_MIC_SHORT])
         |=> status[`MEIA_BIT_MIC_SHORT]
   ) else $error("falling mic short edge did not latch");

   chk_codec_rises: assert property ( // RULE9
      @(posedge core_clk_i) disable iff (!arst_n_i)
      ($rose(ev_bus.level[`MEIA_BIT_CODEC_DONE]) && !mask[`MEIA_BIT_CODEC_DONE])
         |=> status[`MEIA_BIT_CODEC_DONE]
   ) else $error("codec done event did not latch");

   chk_warn_rises: assert property ( // RULE11
      @(posedge core_clk_i) disable iff (!arst_n_i)
      ($rose(ev_bus.level[`MEIA_BIT_TEMP_WARN]) && !mask[`MEIA_BIT_TEMP_WARN])
         |=> status[`MEIA_BIT_TEMP_WARN]
   ) else $error("warning temperature event did not latch");

   chk_rise_sources: assert property ( // RULE5
      @(posedge core_clk_i) disable iff (!arst_n_i)
      ((status & ~$past(status) & ~$past(ev_bus.level) & ~`MEIA_BOTH_EDGES) == 16'h0000)
   ) else $error("rise-only event latched without high level");

   chk_pin_idle: assert property ( // RULE8
      @(posedge core_clk_i) disable iff (!arst_n_i)
      (status == 16'h0000) |=> (host_interrupt_request_low_o && !irq_o)
   ) else $error("interrupt active with status clear");

   chk_irq_active: assert property ( // RULE7
      @(posedge core_clk_i) disable iff (!arst_n_i)
      (|status) |=> irq_o
   ) else $error("interrupt output low with status set");

endmodule

// ### hw/meia_defs.svh
// Purpose: register indices, field positions and reset values of the event aggregator
// Assumes: byte address of a register is four times its index
// Notes: definitions only
`ifndef MEIA_DEFS_SVH
`define MEIA_DEFS_SVH

`define MEIA_IDX_STATUS 8'h4F
`define MEIA_IDX_MASK 8'h50
`define MEIA_IDX_LIVE 8'h51
`define MEIA_ADDR_W 10

`define MEIA_STATUS_RST 16'h0000
`define MEIA_MASK_RST 16'h0000
`define MEIA_LIVE_RST 16'h0000
`define MEIA_BOTH_EDGES 16'hF000

`define MEIA_BIT_MIC_CURRENT 15
`define MEIA_BIT_MIC_SHORT 14
`define MEIA_BIT_LEFT_JACK 13
`define MEIA_BIT_RIGHT_JACK 12
`define MEIA_BIT_CODEC_DONE 11
`define MEIA_BIT_RESET_DELAY 10
`define MEIA_BIT_TEMP_HIGH 9
`define MEIA_BIT_TEMP_WARN 8
`define MEIA_BIT_BATTERY 7
`define MEIA_BIT_LOCKOUT 6
`define MEIA_BIT_BUCK2 5
`define MEIA_BIT_BUCK1 4
`define MEIA_BIT_LINREG4 3
`define MEIA_BIT_LINREG3 2
`define MEIA_BIT_LINREG2 1
`define MEIA_BIT_LINREG1 0

`endif

// ### hw/meia_pkg.sv
// Purpose: shared types of the event aggregator
// Assumes: sixteen event sources
// Notes: constants live in meia_defs.svh
package meia_pkg;
   typedef logic [15:0] meia_evvec_type;
   typedef enum logic {MEIA_IDLE, MEIA_ANSWER} meia_bus_state_type;
endpackage

// ### hw/meia_edge_if.sv
// Purpose: carries synchronised levels and edge pulses between modules
// Assumes: one clock domain
// Notes: pulse is one cycle wide
interface meia_edge_if #(parameter int WIDTH = 16);
   logic [WIDTH-1:0] level;
   logic [WIDTH-1:0] pulse;
   modport src (output level, output pulse);
   modport dst (input level, input pulse);
endinterface

// ### hw/meia_event_edge.sv
// Purpose: synchronise event conditions and detect their edges
// Assumes: conditions arrive already debounced, from outside this clock
// Notes: bits set in BOTH_EDGES fire on both edges, the rest on rising only
module meia_event_edge #(
   parameter int WIDTH = 16,
   parameter logic [WIDTH-1:0] BOTH_EDGES = '0
) (
   input wire logic core_clk_i,
   input wire logic arst_n_i,
   input wire logic [WIDTH-1:0] cond_i,
   meia_edge_if.src ev
);
   logic [WIDTH-1:0] sync1;
   logic [WIDTH-1:0] sync2;
   logic [WIDTH-1:0] prev;

   always_ff @(posedge core_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         sync1 <= '0;
         sync2 <= '0;
         prev <= '0;
      end else begin
         sync1 <= cond_i;
         sync2 <= sync1;
         prev <= sync2;
      end
   end

   assign ev.level = sync2;
   // RULE4 both edges
   // RULE5 rising only
   assign ev.pulse = (sync2 & ~prev) | (BOTH_EDGES & ~sync2 & prev);
endmodule

// ### tb/meia_host_model.sv
// Purpose: host side of the register bus, an Avalon-MM master issuing single transfers
// Assumes: slave answers through waitrequest, byte address is four times the index
// Notes: the bench timeout ends a wait that never completes
module meia_host_model #(
   parameter int ADDR_W = 10
) (
   input wire logic core_clk_i,
   output logic [ADDR_W-1:0] avs_address,
   output logic avs_read,
   output logic avs_write,
   output logic [31:0] avs_writedata,
   output logic [3:0] avs_byteenable,
   input wire logic [31:0] avs_readdata,
   input wire logic avs_waitrequest
);
   timeunit 1ns;
   timeprecision 1ps;

   initial begin
      avs_address = '0;
      avs_read = 1'b0;
      avs_write = 1'b0;
      avs_writedata = 32'h00000000;
      avs_byteenable = 4'h0;
   end

   // request held until waitrequest is sampled low, then dropped
   task automatic xfer(input logic wr, input logic [7:0] idx, input logic [15:0] d,
                       output logic [15:0] q, input logic [3:0] be = 4'hF);
      @(posedge core_clk_i);
      avs_address <= ADDR_W'({idx, 2'b00});
      avs_read <= !wr;
      avs_write <= wr;
      avs_writedata <= {16'h0000, d};
      avs_byteenable <= be;
      do @(posedge core_clk_i); while (avs_waitrequest !== 1'b0);
      q = avs_readdata[15:0];
      avs_read <= 1'b0;
      avs_write <= 1'b0;
   endtask
endmodule

// ### tb/monitor_event_interrupt_aggregator_tb.sv
// Purpose: self-checking bench of the event aggregator
// Assumes: events held for many cycles, well above the two-cycle minimum
// Notes: random masks and event vectors from a fixed-seed shift register
`include "meia_defs.svh"

module monitor_event_interrupt_aggregator_tb;
   import meia_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;

   logic core_clk_i = 1'b0;
   logic arst_n_i = 1'b0;
   meia_evvec_type ev = '0;
   logic [9:0] avs_address;
   logic avs_read, avs_write, avs_waitrequest, pin, irq;
   logic [31:0] avs_writedata, avs_readdata;
   logic [3:0] avs_byteenable;
   int n_mismatch = 0;
   int total_checks = 0;
   int cyc = 0;
   logic [31:0] seed = 32'd69059;
   logic [15:0] q, r1;

   always #5 core_clk_i = ~core_clk_i;

   meia_host_model #(.ADDR_W(10)) meia_host_model_inst (.core_clk_i(core_clk_i),
      .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
      .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));

   meia_top #(.ADDR_W(10)) meia_top_inst (.core_clk_i(core_clk_i), .arst_n_i(arst_n_i),
      .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
      .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
      .mic_current_event_i(ev[15]), .mic_short_event_i(ev[14]), .left_jack_event_i(ev[13]),
      .right_jack_event_i(ev[12]), .codec_sequence_done_event_i(ev[11]),
      .reset_delay_fault_event_i(ev[10]), .temp_high_event_i(ev[9]),
      .temp_warn_event_i(ev[8]), .battery_comparator_event_i(ev[7]),
      .supply_lockout_event_i(ev[6]), .buck2_undervoltage_event_i(ev[5]),
      .buck1_undervoltage_event_i(ev[4]), .linreg4_undervoltage_event_i(ev[3]),
      .linreg3_undervoltage_event_i(ev[2]), .linreg2_undervoltage_event_i(ev[1]),
      .linreg1_undervoltage_event_i(ev[0]), .host_interrupt_request_low_o(pin),
      .irq_o(irq));

   function automatic logic [31:0] lfsr_next(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction

   // jack and mic bits latch on both edges, the rest on rising only
   function automatic meia_evvec_type exp_status(input meia_evvec_type o, input meia_evvec_type n,
                                                 input meia_evvec_type m);
      return ((n & ~o) | (o & ~n & 16'hF000)) & ~m;
   endfunction

   task automatic check_reg(input logic [15:0] got, input logic [15:0] exp);
      total_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("Error at %0t: register got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic check_pin(input logic [1:0] got, input logic [1:0] exp);
      total_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("Error at %0t: pin and irq got %b expected %b", $time, got, exp);
      end
   endtask

   task automatic step(input meia_evvec_type v, input meia_evvec_type m);
      meia_evvec_type e;
      e = exp_status(ev, v, m);
      ev <= v;
      repeat (6) @(posedge core_clk_i);
      check_pin({pin, irq}, (e == 16'h0000) ? 2'b10 : 2'b01);
      meia_host_model_inst.xfer(1'b0, `MEIA_IDX_LIVE, 16'h0000, q);
      check_reg(q, v);
      meia_host_model_inst.xfer(1'b0, `MEIA_IDX_STATUS, 16'h0000, q);
      check_reg(q, e);
      meia_host_model_inst.xfer(1'b0, `MEIA_IDX_STATUS, 16'h0000, q);
      check_reg(q, 16'h0000);
      check_pin({pin, irq}, 2'b10);
   endtask

   task automatic results();
      $display("mismatches %0d, checks %0d", n_mismatch, total_checks);
      if (n_mismatch == 0 && total_checks > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   always @(posedge core_clk_i) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         n_mismatch++;
         results();
      end
   end

   initial begin
      repeat (4) @(posedge core_clk_i);
      arst_n_i <= 1'b1;
      meia_host_model_inst.xfer(1'b0, `MEIA_IDX_STATUS, 16'h0000, q);
      check_reg(q, `MEIA_STATUS_RST);
      meia_host_model_inst.xfer(1'b0, `MEIA_IDX_MASK, 16'h0000, q);
      check_reg(q, `MEIA_MASK_RST);
      meia_host_model_inst.xfer(1'b1, `MEIA_IDX_LIVE, 16'hFFFF, q);
      meia_host_model_inst.xfer(1'b0, `MEIA_IDX_LIVE, 16'h0000, q);
      check_reg(q, 16'h0000);
      meia_host_model_inst.xfer(1'b0, 8'h52, 16'h0000, q);
      check_reg(q, 16'h0000);
      // each source alone, rise then fall, with no mask
      for (int i = 0; i < 16; i++) begin
         step(meia_evvec_type'(1) << i, 16'h0000);
         step(16'h0000, 16'h0000);
      end
      // random masks over random event vectors, low linear regulators masked first
      for (int k = 0; k < 9; k++) begin
         seed = lfsr_next(seed);
         r1 = (k == 0) ? 16'h000F : seed[31:16];
         meia_host_model_inst.xfer(1'b1, `MEIA_IDX_MASK, r1, q);
         meia_host_model_inst.xfer(1'b0, `MEIA_IDX_MASK, 16'h0000, q);
         check_reg(q, r1);
         step((k == 0) ? 16'hFFFF : seed[15:0], r1);
         step(16'h0000, r1);
      end
      meia_host_model_inst.xfer(1'b1, `MEIA_IDX_MASK, 16'h0000, q);
      // event landing around a clearing read must survive it
      for (int d = 0; d < 6; d++) begin
         ev <= ev ^ 16'h8000;
         repeat (d) @(posedge core_clk_i);
         meia_host_model_inst.xfer(1'b0, `MEIA_IDX_STATUS, 16'h0000, r1);
         repeat (4) @(posedge core_clk_i);
         meia_host_model_inst.xfer(1'b0, `MEIA_IDX_STATUS, 16'h0000, q);
         check_reg((r1 | q) & 16'h8000, 16'h8000);
      end
      // lane 0 alone reaches mask bits 7:0
      meia_host_model_inst.xfer(1'b1, `MEIA_IDX_MASK, 16'hFFFF, q, 4'h1);
      meia_host_model_inst.xfer(1'b0, `MEIA_IDX_MASK, 16'h0000, q);
      check_reg(q, 16'h00FF);
      // reset in mid-run brings the mask back to zero
      arst_n_i <= 1'b0;
      repeat (2) @(posedge core_clk_i);
      arst_n_i <= 1'b1;
      meia_host_model_inst.xfer(1'b0, `MEIA_IDX_MASK, 16'h0000, q);
      check_reg(q, `MEIA_MASK_RST);
      // write-one-to-clear, gated by byte lane
      ev <= 16'hF000;
      repeat (6) @(posedge core_clk_i);
      meia_host_model_inst.xfer(1'b1, `MEIA_IDX_STATUS, 16'h9000, q, 4'h2);
      meia_host_model_inst.xfer(1'b1, `MEIA_IDX_STATUS, 16'h2000, q, 4'h1);
      check_pin({pin, irq}, 2'b01);
      meia_host_model_inst.xfer(1'b0, `MEIA_IDX_STATUS, 16'h0000, q);
      check_reg(q, 16'h6000);
      step(16'h0000, 16'h0000);
      results();
   end
endmodule
